// ---- hw/tcc_pkg.sv ----
package tcc_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int          NCH         = 2;
  localparam int          CNT_W       = 16;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_COUNT   = 8'h04;
  localparam logic [7:0]  OFS_MOD     = 8'h08;
  localparam logic [7:0]  OFS_CH_CTL  = 8'h0C;
  localparam logic [7:0]  OFS_CH_HI   = 8'h10;
  localparam logic [7:0]  OFS_CH_LO   = 8'h14;
  localparam logic [7:0]  CH_STRIDE   = 8'h0C;

  // ****************************************
  // field positions
  // ****************************************
  localparam int          CTRL_HALT_BIT  = 5;
  localparam int          CTRL_RST_BIT   = 4;
  localparam int          CH_FLAG_BIT    = 7;
  localparam int          CH_IE_BIT      = 6;
  localparam int          CH_BUF_BIT     = 5;
  localparam int          CH_MSA_BIT     = 4;
  localparam int          CH_ELS_HI_BIT  = 3;
  localparam int          CH_ELS_LO_BIT  = 2;
  localparam int          CH_TOV_BIT     = 1;
  localparam int          CH_MAX_BIT     = 0;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic              HALT_RST = 1'b1;
  localparam logic [CNT_W-1:0]  MOD_RST  = 16'hFFFF;
  localparam logic [CNT_W-1:0]  CNT_RST  = 16'h0000;
  localparam logic [6:0]        CTL_RST  = 7'h00;
  localparam logic              PIN_RST  = 1'b1;

  // ****************************************
  // bus
  // ****************************************
  localparam int          HTRANS_ACTIVE_BIT = 1;

  typedef enum logic [1:0] {
    ELS_OFF         = 2'b00,
    ELS_RISE_TOGGLE = 2'b01,
    ELS_FALL_CLEAR  = 2'b10,
    ELS_BOTH_SET    = 2'b11
  } els_t;

endpackage

// ---- hw/timer_channel_capture_compare.sv ----
// Summary of operation
// - capture mode: selected pin edge sets flag and copies counter into channel value
// - compare mode: counter equal to channel value sets the flag
// - flag clears by control read with flag set, then zero write; new event wins
// - writing one to flag does nothing; reset clears flag and control bits
// - interrupt request is flag and enable together
// - buffered select forces buffered compare or pwm regardless of other mode bit
// - buffered bit only in channel 0; it disables channel 1 and frees its pin
// - with edge field nonzero and no buffering, mode bit picks capture or compare
// - edge field zero: mode bit one presets low, zero presets high
// - edge field zero: channel lets go of its pin
// - capture edges: 01 rising, 10 falling, 11 both
// - compare action: 01 toggle, 10 low, 11 high
// - toggle-on-overflow flips pin at every overflow in compare mode only
// - overflow action beats a coinciding compare action
// - full-duty bit forces 100% pwm, taking effect from next period; code forces it only while toggle-on-overflow is clear
// - channel value holds capture or compare value; unknown after reset
// - capture mode: high byte read blocks captures until low byte read
// - compare modes: high byte write blocks matches until low byte written
// - counter at modulo signals overflow and restarts from zero
// - halt with counter reset holds counter stopped at zero
//
// Implementation choices: the address map and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none

module timer_channel_capture_compare
  import tcc_pkg::*;
(
  input  wire  logic              i_clk,
  input  wire  logic              i_nrst,
  input  wire  logic              i_hsel,
  input  wire  logic [31:0]       i_haddr,
  input  wire  logic [1:0]        i_htrans,
  input  wire  logic              i_hwrite,
  input  wire  logic [2:0]        i_hsize,
  input  wire  logic [31:0]       i_hwdata,
  input  wire  logic              i_hready,
  output var   logic [31:0]       o_hrdata,
  output var   logic              o_hreadyout,
  output var   logic              o_hresp,
  input  wire  logic [NCH-1:0]    i_chan_pin,
  output var   logic [NCH-1:0]    o_chan_pin,
  output var   logic [NCH-1:0]    o_chan_pin_oe,
  output var   logic [NCH-1:0]    o_irq
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic pin_action(input logic [1:0] e, input logic p);
    case (e)
      ELS_RISE_TOGGLE: pin_action = ~p;
      ELS_FALL_CLEAR:  pin_action = 1'b0;
      ELS_BOTH_SET:    pin_action = 1'b1;
      default:         pin_action = p;
    endcase
  endfunction

  function automatic logic full_level(input logic [1:0] e, input logic p);
    case (e)
      ELS_FALL_CLEAR:  full_level = 1'b1;
      ELS_BOTH_SET:    full_level = 1'b0;
      default:         full_level = p;
    endcase
  endfunction

  // ****************************************
  // state
  // ****************************************
  logic [CNT_W-1:0]  cnt_q;
  logic [CNT_W-1:0]  mod_q;
  logic              halt_q;
  logic [6:0]        ctl_q [NCH];
  logic [CNT_W-1:0]  val_q [NCH];
  logic [NCH-1:0]    flag_q;
  logic [NCH-1:0]    arm_q;
  logic [NCH-1:0]    rd_lock_q;
  logic [NCH-1:0]    wr_lock_q;
  logic [NCH-1:0]    max_eff_q;
  logic [NCH-1:0]    pin_q;
  logic [NCH-1:0]    oe_q;
  logic [NCH-1:0]    irq_q;
  logic [NCH-1:0]    sync1_q;
  logic [NCH-1:0]    sync2_q;
  logic [NCH-1:0]    sync3_q;
  logic              act_sel_q;
  logic              last_wr_q;
  logic [31:0]       rdata_q;
  logic              wr_q;
  logic [7:0]        waddr_q;

  // ****************************************
  // bus decode
  // ****************************************
  logic              acc;
  logic              rd_acc;
  logic [7:0]        a_addr;
  logic              in_map;
  logic [7:0]        wd;
  logic              we_ctrl;
  logic              we_mod;
  logic              buf_on;
  logic              ovf;
  logic              cnt_rst;
  logic [31:0]       rd_mux;

  assign acc     = i_hsel && i_htrans[HTRANS_ACTIVE_BIT] && i_hready;
  assign rd_acc  = acc && !i_hwrite;
  assign a_addr  = i_haddr[7:0];
  assign in_map  = (i_haddr[31:8] == 24'h000000);
  assign wd      = i_hwdata[7:0];
  assign we_ctrl = wr_q && (waddr_q == OFS_CTRL);
  assign we_mod  = wr_q && (waddr_q == OFS_MOD);
  assign cnt_rst = we_ctrl && wd[CTRL_RST_BIT];
  assign buf_on  = ctl_q[0][CH_BUF_BIT];

  // ****************************************
  // counter
  // ****************************************
  // modulo overflow
  assign ovf = !halt_q && !cnt_rst && (cnt_q == mod_q);

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_q  <= CNT_RST;
      mod_q  <= MOD_RST;
      halt_q <= HALT_RST;
    end else begin
      if (we_ctrl) begin
        halt_q <= wd[CTRL_HALT_BIT];
      end
      if (we_mod) begin
        mod_q <= i_hwdata[CNT_W-1:0];
      end
      if (cnt_rst) begin
        cnt_q <= CNT_RST;
      end else if (ovf) begin
        cnt_q <= CNT_RST;
      end else if (!halt_q) begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

  // ****************************************
  // channels
  // ****************************************
  logic [1:0]        els [NCH];
  logic [CNT_W-1:0]  cmp_val [NCH];
  logic [NCH-1:0]    live, bufm, msa, cap_md, cmp_md, rise, fall;
  logic [NCH-1:0]    edge_hit, match, evt, tov_on, pin_d, oe_d;
  logic [NCH-1:0]    rd_ctl, rd_hi, rd_lo, we_ctl, we_hi, we_lo, we_zero;
  logic [7:0]        ch_rd [NCH];

  for (genvar g = 0; g < NCH; g++) begin : g_ch
    localparam logic [7:0] BASE = 8'(g) * CH_STRIDE;
    assign rd_ctl[g]  = rd_acc && in_map && (a_addr == OFS_CH_CTL + BASE);
    assign rd_hi[g]   = rd_acc && in_map && (a_addr == OFS_CH_HI + BASE);
    assign rd_lo[g]   = rd_acc && in_map && (a_addr == OFS_CH_LO + BASE);
    // channel 1 control is dead while buffering
    assign we_ctl[g]  = wr_q && live[g] && (waddr_q == OFS_CH_CTL + BASE);
    assign we_hi[g]   = wr_q && (waddr_q == OFS_CH_HI + BASE);
    assign we_lo[g]   = wr_q && (waddr_q == OFS_CH_LO + BASE);
    assign we_zero[g] = we_ctl[g] && !wd[CH_FLAG_BIT];
    assign els[g]     = ctl_q[g][CH_ELS_HI_BIT:CH_ELS_LO_BIT];
    assign msa[g]     = ctl_q[g][CH_MSA_BIT];
    assign live[g]    = (g == 0) || !buf_on;
    assign bufm[g]    = (g == 0) && buf_on;
    assign cap_md[g]  = live[g] && (els[g] != ELS_OFF) && !bufm[g] && !msa[g];
    assign cmp_md[g]  = live[g] && (els[g] != ELS_OFF) && (msa[g] || bufm[g]);
    assign cmp_val[g] = bufm[g] ? val_q[act_sel_q] : val_q[g];
    assign rise[g]    = sync2_q[g] && !sync3_q[g];
    assign fall[g]    = !sync2_q[g] && sync3_q[g];
    assign edge_hit[g] = cap_md[g] && !rd_lock_q[g] &&
                         ((els[g] == ELS_RISE_TOGGLE && rise[g]) ||
                          (els[g] == ELS_FALL_CLEAR && fall[g]) ||
                          (els[g] == ELS_BOTH_SET && (rise[g] || fall[g])));
    assign match[g]   = cmp_md[g] && !wr_lock_q[g] && !halt_q && (cnt_q == cmp_val[g]);
    assign evt[g]     = edge_hit[g] || match[g];
    // toggle on overflow only in compare
    assign tov_on[g]  = cmp_md[g] && ctl_q[g][CH_TOV_BIT];
    assign pin_d[g]   = !cmp_md[g] ? ((els[g] == ELS_OFF) ? !msa[g] : pin_q[g]) :
                        (tov_on[g] && ovf) ? !pin_q[g] :
                        (max_eff_q[g] && !ctl_q[g][CH_TOV_BIT]) ?
                          full_level(els[g], pin_q[g]) :
                        match[g] ? pin_action(els[g], pin_q[g]) : pin_q[g];
    // pin released when edge field is zero
    assign oe_d[g]    = cmp_md[g];
    assign ch_rd[g]   = (a_addr == OFS_CH_CTL + BASE) ?
                          (live[g] ? {flag_q[g], ctl_q[g]} : 8'h00) :
                        (a_addr == OFS_CH_HI + BASE) ? val_q[g][15:8] :
                        (a_addr == OFS_CH_LO + BASE) ? val_q[g][7:0] : 8'h00;
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      for (int i = 0; i < NCH; i++) begin
        ctl_q[i] <= CTL_RST;
      end
      flag_q    <= '0;
      arm_q     <= '0;
      rd_lock_q <= '0;
      wr_lock_q <= '0;
      max_eff_q <= '0;
      pin_q     <= {NCH{PIN_RST}};
      oe_q      <= '0;
      irq_q     <= '0;
      act_sel_q <= 1'b0;
      last_wr_q <= 1'b0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        // control write replaces all control bits, bit 5 only on channel 0
        if (we_ctl[i]) begin
          ctl_q[i] <= (i == 0) ? wd[6:0] : (wd[6:0] & 7'h5F);
        end
        // clear needs armed read, event wins
        if (evt[i]) begin
          flag_q[i] <= 1'b1;
        end else if (we_zero[i] && arm_q[i]) begin
          flag_q[i] <= 1'b0;
        end
        if (evt[i] || we_ctl[i]) begin
          arm_q[i] <= 1'b0;
        end else if (rd_ctl[i] && flag_q[i]) begin
          arm_q[i] <= 1'b1;
        end
        if (rd_lo[i]) begin
          rd_lock_q[i] <= 1'b0;
        end else if (rd_hi[i] && cap_md[i]) begin
          rd_lock_q[i] <= 1'b1;
        end
        if (we_lo[i]) begin
          wr_lock_q[i] <= 1'b0;
        end else if (we_hi[i] && !cap_md[i]) begin
          wr_lock_q[i] <= 1'b1;
        end
        // new duty setting from next period
        if (ovf) begin
          max_eff_q[i] <= ctl_q[i][CH_MAX_BIT];
        end
        pin_q[i] <= pin_d[i];
        oe_q[i]  <= oe_d[i];
        irq_q[i] <= flag_q[i] && ctl_q[i][CH_IE_BIT];
      end
      if (buf_on && we_lo[1]) begin
        last_wr_q <= 1'b1;
      end else if (buf_on && we_lo[0]) begin
        last_wr_q <= 1'b0;
      end
      if (ovf) begin
        act_sel_q <= last_wr_q;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    for (int i = 0; i < NCH; i++) begin
      if (we_hi[i]) begin
        val_q[i][15:8] <= wd;
      end else if (we_lo[i]) begin
        val_q[i][7:0] <= wd;
      end else if (edge_hit[i]) begin
        val_q[i] <= cnt_q;
      end
    end
  end

  // ****************************************
  // pin synchroniser
  // ****************************************
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= i_chan_pin;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // ****************************************
  // bus slave
  // ****************************************
  assign rd_mux = !in_map ? 32'h00000000 :
                  (a_addr == OFS_CTRL) ? {26'h0000000, halt_q, 5'h00} :
                  (a_addr == OFS_COUNT) ? {16'h0000, cnt_q} :
                  (a_addr == OFS_MOD) ? {16'h0000, mod_q} :
                  {24'h000000, ch_rd[0] | ch_rd[1]};

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_q <= 32'h00000000;
      wr_q    <= 1'b0;
      waddr_q <= 8'h00;
    end else begin
      wr_q    <= acc && i_hwrite && in_map;
      waddr_q <= a_addr;
      if (rd_acc) begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign o_hrdata      = rdata_q;
  assign o_hreadyout   = 1'b1;
  assign o_hresp       = 1'b0;
  assign o_chan_pin    = pin_q;
  assign o_chan_pin_oe = oe_q;
  assign o_irq         = irq_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_armed_zero;
    arm_q[0] && we_zero[0] && !evt[0];
  endsequence

  a_capture_copy: assert property (edge_hit[0] |=> flag_q[0] && val_q[0] == $past(cnt_q))
    else $error("capture did not set flag and copy count");
  a_compare_flag: assert property (match[1] |=> flag_q[1])
    else $error("compare match did not set flag");
  a_flag_clear: assert property (s_armed_zero |=> !flag_q[0])
    else $error("armed zero write did not clear flag");
  a_flag_fall_armed: assert property ($fell(flag_q[0]) |-> $past(arm_q[0] && we_zero[0]))
    else $error("flag cleared without sequence");
  a_flag_one_write: assert property (!flag_q[0] && !evt[0] |=> !flag_q[0])
    else $error("flag set without event");
  a_irq_gate: assert property (o_irq[0] == $past(flag_q[0] && ctl_q[0][CH_IE_BIT]))
    else $error("interrupt not flag and enable");
  a_buf_ch1_off: assert property (buf_on |=> !o_chan_pin_oe[1])
    else $error("channel 1 pin driven while buffering");
  a_port_release: assert property (els[0] == ELS_OFF |=> !o_chan_pin_oe[0])
    else $error("pin driven with edge field zero");
  a_preset_level: assert property (els[0] == ELS_OFF |=> o_chan_pin[0] == !$past(msa[0]))
    else $error("preset level wrong");
  a_ovf_priority: assert property (tov_on[0] && ovf |=> o_chan_pin[0] != $past(pin_q[0]))
    else $error("overflow toggle lost");
  a_rd_lock_cap: assert property (rd_hi[0] && cap_md[0] && !rd_lo[0] |=> !edge_hit[0])
    else $error("capture after high byte read");
  a_modulo_wrap: assert property (ovf |=> cnt_q == CNT_RST)
    else $error("counter did not wrap at modulo");
  a_halt_zero: assert property (halt_q && cnt_q == CNT_RST && !we_ctrl |=> cnt_q == CNT_RST)
    else $error("halted counter moved");

endmodule

`default_nettype wire

// ---- tb/pin_partner.sv ----
`timescale 1ns/100ps
`default_nettype none

module pin_partner
  import tcc_pkg::*;
(
  input  wire logic [NCH-1:0]  i_level,
  input  wire logic            i_clk,
  input  wire logic [NCH-1:0]  i_drive,
  input  wire logic [NCH-1:0]  i_dut_pin,
  input  wire logic [NCH-1:0]  i_dut_oe,
  output var  logic [NCH-1:0]  o_wire
);
  logic [NCH-1:0]  last_q;

  always_ff @(posedge i_clk) begin
    last_q <= o_wire;
  end

  // ****************************************
  // resolved pin level
  // ****************************************
  // pin owner and stable drive
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      if (i_dut_oe[i]) begin
        o_wire[i] = i_dut_pin[i];
      end else if (i_drive[i]) begin
        o_wire[i] = i_level[i];
      end else begin
        o_wire[i] = ~last_q[i];
      end
    end
  end
endmodule

`default_nettype wire

// ---- tb/timer_channel_capture_compare_tb.sv ----
`timescale 1ns/100ps
`default_nettype none

module timer_channel_capture_compare_tb
  import tcc_pkg::*;
;
  logic            i_clk;
  logic            i_nrst;
  logic            i_hsel;
  logic [31:0]     i_haddr;
  logic [1:0]      i_htrans;
  logic            i_hwrite;
  logic [31:0]     i_hwdata;
  logic [31:0]     o_hrdata;
  logic            o_hreadyout;
  logic            o_hresp;
  logic [NCH-1:0]  pin_w;
  logic [NCH-1:0]  o_chan_pin;
  logic [NCH-1:0]  o_chan_pin_oe;
  logic [NCH-1:0]  o_irq;
  logic [NCH-1:0]  drv_level;
  logic [7:0]      cfg;
  logic            hit;
  int              mismatches;
  int              samples_checked;

  timer_channel_capture_compare timer_channel_capture_compare_inst (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_hsel(i_hsel), .i_haddr(i_haddr),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'b010), .i_hwdata(i_hwdata),
    .i_hready(o_hreadyout), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
    .o_hresp(o_hresp), .i_chan_pin(pin_w), .o_chan_pin(o_chan_pin),
    .o_chan_pin_oe(o_chan_pin_oe), .o_irq(o_irq));

  pin_partner pin_partner_inst (.i_clk(i_clk), .i_level(drv_level), .i_drive(2'b11),
    .i_dut_pin(o_chan_pin), .i_dut_oe(o_chan_pin_oe), .o_wire(pin_w));

  always #5 i_clk = ~i_clk;

  // ****************************************
  // bus and check tasks
  // ****************************************
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] wd,
                     output logic [31:0] rdat);
    int n;
    n = 0;
    @(posedge i_clk);
    i_hsel   <= 1'b1;
    i_haddr  <= {24'h000000, a};
    i_htrans <= 2'b10;
    i_hwrite <= wr;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_hreadyout !== 1'b1 && n < 50);
    i_hsel   <= 1'b0;
    i_htrans <= 2'b00;
    i_hwdata <= {16'h0000, wd};
    do begin
      @(posedge i_clk);
      n++;
    end while (o_hreadyout !== 1'b1 && n < 100);
    rdat = o_hrdata;
    check("hresp", 32'h0, {31'h0, o_hresp});
    if (n >= 100) begin
      mismatches++;
      $display("BAD hreadyout expected 1 seen %b", o_hreadyout);
      test_done();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rc(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 16'h0000, x);
    check(what, exp, x);
  endtask

  // read control to arm, then write the new setting with flag zero
  task automatic arm_clear(input logic [7:0] c);
    logic [31:0] x;
    bus(1'b0, OFS_CH_CTL, 16'h0000, x);
    wr(OFS_CH_CTL, {8'h00, c});
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  initial begin
    repeat (60000) @(posedge i_clk);
    mismatches++;
    test_done();
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    i_clk = 1'b0;
    i_nrst = 1'b0;
    i_hsel = 1'b0;
    i_haddr = 32'h00000000;
    i_htrans = 2'b00;
    i_hwrite = 1'b0;
    i_hwdata = 32'h00000000;
    drv_level = 2'b00;
    mismatches = 0;
    samples_checked = 0;
    repeat (20) @(posedge i_clk);
    i_nrst <= 1'b1;
    rc("counter control", OFS_CTRL, 32'h00000020);
    rc("modulo", OFS_MOD, 32'h0000FFFF);
    rc("ch0 control", OFS_CH_CTL, 32'h0);
    rc("ch1 control", OFS_CH_CTL + CH_STRIDE, 32'h0);
    rc("unmapped", 8'hF0, 32'h0);
    check("pin enable", 32'h0, {30'h0, o_chan_pin_oe});
    $display("test reset done");
    wr(OFS_CTRL, 16'h0030);
    rc("count cleared", OFS_COUNT, 32'h0);
    for (int e = 1; e < 4; e++) begin
      cfg = 8'h40 | 8'(e << 2);
      // pin held still before capture is enabled
      cyc(3);
      wr(OFS_CH_CTL, {8'h00, cfg});
      for (int lv = 1; lv >= 0; lv--) begin
        wr(OFS_CH_HI, 16'h0012);
        wr(OFS_CH_LO, 16'h0034);
        arm_clear(cfg);
        drv_level[0] <= lv[0];
        cyc(8);
        hit = (lv == 1) ? e[0] : e[1];
        rc("capture flag", OFS_CH_CTL, {24'h0, hit, cfg[6:0]});
        check("irq", {31'h0, hit}, {30'h0, o_irq});
        rc("captured high", OFS_CH_HI, hit ? 32'h0 : 32'h12);
        rc("captured low", OFS_CH_LO, hit ? 32'h0 : 32'h34);
      end
    end
    wr(OFS_CH_HI, 16'h0012);
    wr(OFS_CH_LO, 16'h0034);
    rc("locked high", OFS_CH_HI, 32'h12);
    drv_level[0] <= 1'b1;
    cyc(8);
    rc("locked low", OFS_CH_LO, 32'h34);
    drv_level[0] <= 1'b0;
    cyc(8);
    rc("flag set", OFS_CH_CTL, 32'hCC);
    wr(OFS_CH_CTL, 16'h008C);
    cyc(2);
    check("irq masked", 32'h0, {31'h0, o_irq[0]});
    wr(OFS_CH_CTL, 16'h004C);
    rc("flag kept", OFS_CH_CTL, 32'hCC);
    wr(OFS_CH_CTL, 16'h004C);
    rc("flag cleared", OFS_CH_CTL, 32'h4C);
    wr(OFS_CH_CTL, 16'h00CC);
    rc("flag one ignored", OFS_CH_CTL, 32'h4C);
    $display("test capture done");
    wr(OFS_CTRL, 16'h0030);
    wr(OFS_MOD, 16'h00FF);
    wr(OFS_CH_HI, 16'h0000);
    wr(OFS_CH_LO, 16'h0040);
    wr(OFS_CH_CTL, 16'h0000);
    cyc(2);
    check("preset high", 32'h1, {31'h0, o_chan_pin[0]});
    wr(OFS_CH_CTL, 16'h0010);
    cyc(2);
    check("preset low", 32'h0, {31'h0, o_chan_pin[0]});
    check("preset released", 32'h0, {31'h0, o_chan_pin_oe[0]});
    for (int k = 0; k < 3; k++) begin
      cfg = 8'h10 | 8'((3 - k) << 2);
      wr(OFS_CTRL, 16'h0030);
      arm_clear(cfg);
      wr(OFS_CTRL, 16'h0000);
      cyc(90);
      rc("compare flag", OFS_CH_CTL, {24'h0, 1'b1, cfg[6:0]});
      check("compare pin", {31'h0, k != 1}, {31'h0, o_chan_pin[0]});
      check("compare drive", 32'h1, {31'h0, o_chan_pin_oe[0]});
    end
    wr(OFS_CTRL, 16'h0030);
    arm_clear(8'h18);
    wr(OFS_CH_HI, 16'h0000);
    wr(OFS_CTRL, 16'h0000);
    cyc(90);
    rc("match held off", OFS_CH_CTL, 32'h18);
    wr(OFS_CH_LO, 16'h0040);
    cyc(270);
    rc("match resumed", OFS_CH_CTL, 32'h98);
    $display("test compare done");
    wr(OFS_CTRL, 16'h0030);
    wr(OFS_CH_CTL + CH_STRIDE, 16'h0014);
    cyc(2);
    check("ch1 drive", 32'h1, {31'h0, o_chan_pin_oe[1]});
    check("ch1 level", 32'h1, {31'h0, o_chan_pin[1]});
    arm_clear(8'h2C);
    rc("ch1 disabled", OFS_CH_CTL + CH_STRIDE, 32'h0);
    check("ch1 released", 32'h0, {31'h0, o_chan_pin_oe[1]});
    wr(OFS_CTRL, 16'h0000);
    cyc(300);
    rc("buffered flag", OFS_CH_CTL, 32'hAC);
    check("buffered pin", 32'h1, {31'h0, o_chan_pin[0]});
    // new ch1 value waits for the next overflow
    wr(OFS_CTRL, 16'h0030);
    wr(OFS_CH_HI + CH_STRIDE, 16'h0000);
    wr(OFS_CH_LO + CH_STRIDE, 16'h0080);
    arm_clear(8'h2C);
    wr(OFS_CTRL, 16'h0000);
    cyc(90);
    rc("old buffer used", OFS_CH_CTL, 32'hAC);
    arm_clear(8'h2C);
    cyc(230);
    rc("old buffer gone", OFS_CH_CTL, 32'h2C);
    cyc(60);
    rc("new buffer used", OFS_CH_CTL, 32'hAC);
    $display("test buffered done");
    // set on compare at the overflow count, toggle on overflow
    wr(OFS_CTRL, 16'h0030);
    wr(OFS_CH_LO, 16'h00FF);
    arm_clear(8'h1E);
    wr(OFS_CTRL, 16'h0000);
    cyc(260);
    check("overflow wins", 32'h0, {31'h0, o_chan_pin[0]});
    cyc(256);
    check("overflow toggle", 32'h1, {31'h0, o_chan_pin[0]});
    // clear on compare with full duty, effective after overflow
    wr(OFS_CTRL, 16'h0030);
    wr(OFS_CH_LO, 16'h0040);
    arm_clear(8'h19);
    wr(OFS_CTRL, 16'h0000);
    cyc(100);
    check("full duty pending", 32'h0, {31'h0, o_chan_pin[0]});
    cyc(260);
    check("full duty held", 32'h1, {31'h0, o_chan_pin[0]});
    $display("test overflow done");
    test_done();
  end
endmodule

`default_nettype wire
